// ==== fpw_pkg.sv ====
// package: constants and types of the frequency program watchdog
`default_nettype none
package fpw_pkg;
	// clock and time units
	localparam int CLK_KHZ        = 125000;
	localparam int SHORT_UNIT_MS  = 150;
	localparam int LONG_UNIT_MS   = 2500;
	localparam int SHORT_UNIT_CYC = SHORT_UNIT_MS * CLK_KHZ;
	localparam int LONG_UNIT_CYC  = LONG_UNIT_MS * CLK_KHZ;
	localparam int RST_PULSE_CYC  = 16;
	// gear constant 48.00741 in units of 1e-5
	localparam logic [22:0] GEAR_E5 = 23'h4940e5;
	// register indices on the link port
	localparam logic [3:0] ADDR_CPU_N   = 4'h0;
	localparam logic [3:0] ADDR_CPU_M   = 4'h1;
	localparam logic [3:0] ADDR_REC_N   = 4'h2;
	localparam logic [3:0] ADDR_REC_M   = 4'h3;
	localparam logic [3:0] ADDR_FREQ_CT = 4'h4;
	localparam logic [3:0] ADDR_SW_CODE = 4'h5;
	localparam logic [3:0] ADDR_WD_CTL  = 4'h6;
	localparam logic [3:0] ADDR_WD_TIME = 4'h7;
	// field positions
	localparam int FC_PROG_BIT   = 0;
	localparam int FC_BYPASS_BIT = 1;
	localparam int FC_RECSEL_BIT = 2;
	localparam int WATCHDOG_ENABLE_BIT_BIT     = 0;
	localparam int WD_LONG_BIT   = 1;
	localparam int WD_RSTWD_BIT  = 2;
	localparam int WD_RSTFC_BIT  = 3;
	localparam int WD_FLAG_BIT   = 4;

	typedef struct packed {
		logic [7:0] cpu_n;
		logic [6:0] cpu_m;
		logic [7:0] rec_n;
		logic [6:0] rec_m;
		logic       prog_en;
		logic       bypass;
		logic       rec_sel;
		logic [4:0] sw_code;
		logic       watchdog_enable_bit;
		logic       wd_long;
		logic       rst_wd;
		logic       rst_fc;
		logic [4:0] wd_count;
	} cfg_s;

	localparam cfg_s CFG_RESET = '{cpu_n: 8'h00, cpu_m: 7'h00,
		rec_n: 8'h00, rec_m: 7'h00, prog_en: 1'h0, bypass: 1'h0,
		rec_sel: 1'h0, sw_code: 5'h00, watchdog_enable_bit: 1'h0, wd_long: 1'h0,
		rst_wd: 1'h0, rst_fc: 1'h0, wd_count: 5'h00};

	typedef struct packed {
		logic       prog;
		logic [7:0] n;
		logic [6:0] m;
		logic [4:0] code;
	} freq_s;

	localparam freq_s FREQ_RESET = '{prog: 1'h0, n: 8'h00, m: 7'h00,
		code: 5'h00};

	typedef enum logic [1:0] {
		WD_STOP  = 2'b00,
		WD_WAIT  = 2'b01,
		WD_COUNT = 2'b11
	} wd_state_e;
endpackage : fpw_pkg
`default_nettype wire

// ==== freq_program_watchdog_recovery.sv ====
// module: frequency programming, watchdog and recovery control
// Summary of operation
// [RULE1] programmable mode uses programmed N and M
// [RULE2] either N or M write loads frequency
// [RULE3] host writes N and M together; link_host writes one register per write, and the test often writes N alone
// [RULE4] ratio code from straps or software code
// [RULE5] timeout with select uses recovery N, M
// [RULE6] recovery ratio from straps or software code
// [RULE7] recovery N or M write loads setting
// [RULE8] enable low stops and reloads watchdog
// [RULE9] enabled watchdog counts after frequency change
// [RULE10] timeout flag reads set, write one clears
// [RULE11] timeout is five-bit count of units
// [RULE12] unit select picks 150 ms or 2.5 s
// [RULE13] count reaching zero sets timeout flag
// [RULE14] timeout reset pulse only when enabled
// [RULE15] frequency change reset pulse when enabled
// [RULE16] frequency is gear times (N+3)/(M+3)
// [RULE17] gear constant chosen by active speed code
// [RULE18] host keeps (N+3)/(M+3) above one
// [RULE19] host may use suggested N, M sweeps
// [RULE20] recovery select low uses latched straps
// [RULE21] non-programmable mode uses straps or software
// [RULE22] fixed width pulse, coincident events give one
`timescale 1ns/1ps
`default_nettype none
module freq_program_watchdog_recovery
	import fpw_pkg::*;
#(
	parameter int SHORT_UNIT_CYCLES = SHORT_UNIT_CYC,
	parameter int LONG_UNIT_CYCLES  = LONG_UNIT_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       link_clk,
	input  wire logic [4:0] strap_speed_pins,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_busy,
	output var freq_s       freq_out,
	output logic     [22:0] pll_gear,
	output logic            freq_load,
	output logic            recovery_active,
	output logic            sys_reset_pulse
);

	function automatic cfg_s cfg_write(input cfg_s c,
		input logic [3:0] a, input logic [7:0] d);
		cfg_s r;
		r = c;
		if (a == ADDR_CPU_N) begin
			r.cpu_n = d;
		end else if (a == ADDR_CPU_M) begin
			r.cpu_m = d[6:0];
		end else if (a == ADDR_REC_N) begin
			r.rec_n = d;
		end else if (a == ADDR_REC_M) begin
			r.rec_m = d[6:0];
		end else if (a == ADDR_FREQ_CT) begin
			r.prog_en = d[FC_PROG_BIT];
			r.bypass  = d[FC_BYPASS_BIT];
			r.rec_sel = d[FC_RECSEL_BIT];
		end else if (a == ADDR_SW_CODE) begin
			r.sw_code = d[4:0];
		end else if (a == ADDR_WD_CTL) begin
			r.watchdog_enable_bit   = d[WATCHDOG_ENABLE_BIT_BIT];
			r.wd_long = d[WD_LONG_BIT];
			r.rst_wd  = d[WD_RSTWD_BIT];
			r.rst_fc  = d[WD_RSTFC_BIT];
		end else if (a == ADDR_WD_TIME) begin
			r.wd_count = d[4:0];
		end
		return r;
	endfunction : cfg_write

	function automatic logic [7:0] cfg_read(input cfg_s c,
		input logic flag, input logic [3:0] a);
		logic [7:0] r;
		r = 8'h00;
		if (a == ADDR_CPU_N) begin
			r = c.cpu_n;
		end else if (a == ADDR_CPU_M) begin
			r[6:0] = c.cpu_m;
		end else if (a == ADDR_REC_N) begin
			r = c.rec_n;
		end else if (a == ADDR_REC_M) begin
			r[6:0] = c.rec_m;
		end else if (a == ADDR_FREQ_CT) begin
			r[FC_PROG_BIT]   = c.prog_en;
			r[FC_BYPASS_BIT] = c.bypass;
			r[FC_RECSEL_BIT] = c.rec_sel;
		end else if (a == ADDR_SW_CODE) begin
			r[4:0] = c.sw_code;
		end else if (a == ADDR_WD_CTL) begin
			r[WATCHDOG_ENABLE_BIT_BIT]    = c.watchdog_enable_bit;
			r[WD_LONG_BIT]  = c.wd_long;
			r[WD_RSTWD_BIT] = c.rst_wd;
			r[WD_RSTFC_BIT] = c.rst_fc;
			r[WD_FLAG_BIT]  = flag;
		end else if (a == ADDR_WD_TIME) begin
			r[4:0] = c.wd_count;
		end
		return r;
	endfunction : cfg_read

	// every listed speed code shares one gear value
	function automatic logic [22:0] gear_of(input logic [4:0] code);
		logic [22:0] g;
		g = GEAR_E5;
		if (code > 5'h1f) begin
			g = GEAR_E5;
		end
		return g;
	endfunction : gear_of

	function automatic freq_s active_freq(input cfg_s c,
		input logic [4:0] strap, input logic rec);
		freq_s f;
		f.prog = c.prog_en;                    // see [RULE21]
		f.n    = c.cpu_n;                      // see [RULE1]
		f.m    = c.cpu_m;
		f.code = c.bypass ? c.sw_code : strap; // see [RULE4] [RULE6]
		if (rec && c.rec_sel) begin
			f.prog = 1'b1;                     // see [RULE5]
			f.n    = c.rec_n;
			f.m    = c.rec_m;
		end else if (rec) begin
			f.prog = 1'b0;                     // see [RULE20]
			f.code = strap;
		end
		return f;
	endfunction : active_freq

	// link domain
	cfg_s       shadow;
	logic [3:0] hold_addr;
	logic [7:0] hold_data;
	logic       req_tog;
	logic       ack_s1;
	logic       ack_s2;
	logic       flag_s1;
	logic       flag_s2;
	logic       wr_ok;

	// core domain
	cfg_s       cfg;
	logic       req_s1;
	logic       req_s2;
	logic       req_s3;
	logic       wr_evt;
	logic [4:0] strap_s1;
	logic [4:0] strap_s2;
	logic [4:0] strap_latched;
	logic [1:0] strap_wait;
	logic       ready;
	logic       started;
	logic       wr_cpu_d;
	logic       wr_rec_d;
	logic       w1c;
	freq_s      next_freq;
	logic       load_cpu;
	logic       load_rec;
	logic       fchg;
	logic       rec_prev;
	logic       host_chg;
	wd_state_e  state;
	logic [31:0] unit_cnt;
	logic [31:0] unit_len;
	logic [4:0] wd_cnt;
	logic       unit_end;
	logic       timeout;
	logic       timeout_flag;
	logic       trig;
	logic [4:0] pulse_cnt;

	// writes are refused while the previous one is still crossing
	assign wr_ok = reg_wr && !reg_busy;

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			shadow    <= CFG_RESET;
			hold_addr <= 4'h0;
			hold_data <= 8'h00;
			req_tog   <= 1'b0;
			reg_busy  <= 1'b0;
		end else if (wr_ok) begin
			shadow    <= cfg_write(shadow, reg_addr, reg_wdata);
			hold_addr <= reg_addr;
			hold_data <= reg_wdata;
			req_tog   <= ~req_tog;
			reg_busy  <= 1'b1;
		end else if (ack_s2 == req_tog) begin
			reg_busy  <= 1'b0;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_s1  <= 1'b0;
			ack_s2  <= 1'b0;
			flag_s1 <= 1'b0;
			flag_s2 <= 1'b0;
		end else begin
			ack_s1  <= req_s3;
			ack_s2  <= ack_s1;
			flag_s1 <= timeout_flag;
			flag_s2 <= flag_s1;
		end
	end

	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= cfg_read(shadow, flag_s2, reg_addr); // see [RULE10]
		end
	end

	// shadow and hold stay frozen until req_s3 is echoed back
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tog;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign wr_evt = req_s2 ^ req_s3;
	assign w1c = wr_evt && hold_addr == ADDR_WD_CTL
		&& hold_data[WD_FLAG_BIT];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg      <= CFG_RESET;
			wr_cpu_d <= 1'b0;
			wr_rec_d <= 1'b0;
		end else begin
			if (wr_evt) begin
				cfg <= shadow;
			end
			wr_cpu_d <= wr_evt && (hold_addr == ADDR_CPU_N
				|| hold_addr == ADDR_CPU_M);
			wr_rec_d <= wr_evt && (hold_addr == ADDR_REC_N
				|| hold_addr == ADDR_REC_M);
		end
	end

	// straps are caught once, after the synchroniser has filled
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_s1      <= 5'h00;
			strap_s2      <= 5'h00;
			strap_latched <= 5'h00;
			strap_wait    <= 2'h0;
			started       <= 1'b0;
		end else begin
			strap_s1 <= strap_speed_pins;
			strap_s2 <= strap_s1;
			if (strap_wait != 2'h3) begin
				strap_wait <= strap_wait + 2'h1;
			end
			if (strap_wait == 2'h2) begin
				strap_latched <= strap_s2;
			end
			started <= ready;
		end
	end

	assign ready     = strap_wait == 2'h3;
	assign next_freq = active_freq(cfg, strap_latched, recovery_active);
	assign load_cpu  = wr_cpu_d && cfg.prog_en && !recovery_active;
	assign load_rec  = wr_rec_d && recovery_active && cfg.rec_sel;
	assign fchg      = started && (next_freq != freq_out
		|| load_cpu || load_rec);                 // see [RULE2] [RULE7]
	// a switch into or out of recovery must not rearm the watchdog
	assign host_chg  = fchg && rec_prev == recovery_active;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			freq_out  <= FREQ_RESET;
			pll_gear  <= GEAR_E5;
			freq_load <= 1'b0;
			rec_prev  <= 1'b0;
		end else begin
			if (ready) begin
				freq_out <= next_freq;                 // see [RULE16]
				pll_gear <= gear_of(next_freq.code);   // see [RULE17]
			end
			freq_load <= fchg;
			rec_prev  <= recovery_active;
		end
	end

	// value v lasts v+1 units: 0..31 spans 1..32 units
	assign unit_len = cfg.wd_long ? 32'(LONG_UNIT_CYCLES - 1)
		: 32'(SHORT_UNIT_CYCLES - 1);            // see [RULE12]
	assign unit_end = unit_cnt == unit_len;
	assign timeout  = state == WD_COUNT && cfg.watchdog_enable_bit && !host_chg
		&& unit_end && wd_cnt == 5'h00;          // see [RULE13]

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state    <= WD_STOP;
			unit_cnt <= 32'h0000_0000;
			wd_cnt   <= 5'h00;
		end else if (!cfg.watchdog_enable_bit) begin
			state    <= WD_STOP;                   // see [RULE8]
			unit_cnt <= 32'h0000_0000;
			wd_cnt   <= cfg.wd_count;
		end else begin
			case (state)
				WD_STOP: begin
					state <= WD_WAIT;
				end
				WD_WAIT: begin
					if (host_chg) begin
						state    <= WD_COUNT;      // see [RULE9]
						unit_cnt <= 32'h0000_0000;
						wd_cnt   <= cfg.wd_count;  // see [RULE11]
					end
				end
				WD_COUNT: begin
					if (host_chg) begin
						unit_cnt <= 32'h0000_0000;
						wd_cnt   <= cfg.wd_count;
					end else if (unit_end) begin
						unit_cnt <= 32'h0000_0000;
						if (wd_cnt == 5'h00) begin
							state  <= WD_WAIT;
							wd_cnt <= cfg.wd_count;
						end else begin
							wd_cnt <= wd_cnt - 5'h01;
						end
					end else begin
						unit_cnt <= unit_cnt + 32'h0000_0001;
					end
				end
				default: begin
					state <= WD_STOP;
				end
			endcase
		end
	end

	// a timeout in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_flag    <= 1'b0;
			recovery_active <= 1'b0;
		end else if (timeout) begin
			timeout_flag    <= 1'b1;               // see [RULE13]
			recovery_active <= 1'b1;               // see [RULE5]
		end else if (w1c) begin
			timeout_flag    <= 1'b0;               // see [RULE10]
			recovery_active <= 1'b0;
		end
	end

	assign trig = (timeout && cfg.rst_wd)       // see [RULE14]
		|| (fchg && cfg.rst_fc);                 // see [RULE15]

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pulse_cnt       <= 5'h00;
			sys_reset_pulse <= 1'b0;
		end else if (trig && pulse_cnt == 5'h00) begin
			pulse_cnt       <= 5'(RST_PULSE_CYC - 1); // see [RULE22]
			sys_reset_pulse <= 1'b1;
		end else if (pulse_cnt != 5'h00) begin
			pulse_cnt       <= pulse_cnt - 5'h01;
		end else begin
			sys_reset_pulse <= 1'b0;
		end
	end

	sequence s_expire;
		timeout ##1 (timeout_flag && recovery_active);
	endsequence

	sequence s_pulse;
		sys_reset_pulse [*8];
	endsequence

	property p_flag_set; // see [RULE13]
		@(posedge ref_clk) disable iff (!arst_n)
		timeout |-> s_expire;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_flag_clear; // see [RULE10]
		@(posedge ref_clk) disable iff (!arst_n)
		w1c && !timeout |=> !timeout_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared");

	property p_rst_wd; // see [RULE14]
		@(posedge ref_clk) disable iff (!arst_n)
		timeout && cfg.rst_wd && pulse_cnt == 5'h00 |=> s_pulse;
	endproperty
	a_rst_wd: assert property (p_rst_wd) else $error("no timeout pulse");

	property p_rst_cause; // see [RULE15]
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(sys_reset_pulse) |-> $past(trig);
	endproperty
	a_rst_cause: assert property (p_rst_cause)
		else $error("pulse without cause");

	property p_pulse_width; // see [RULE22]
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(sys_reset_pulse) |-> ##15 sys_reset_pulse;
	endproperty
	a_pulse_width: assert property (p_pulse_width)
		else $error("pulse too short");

	property p_stop_reload; // see [RULE8]
		@(posedge ref_clk) disable iff (!arst_n)
		!cfg.watchdog_enable_bit |=> state == WD_STOP && wd_cnt == $past(cfg.wd_count);
	endproperty
	a_stop_reload: assert property (p_stop_reload)
		else $error("watchdog not reloaded");

	property p_wait_change; // see [RULE9]
		@(posedge ref_clk) disable iff (!arst_n)
		state == WD_WAIT && !host_chg |=> state != WD_COUNT;
	endproperty
	a_wait_change: assert property (p_wait_change)
		else $error("count without change");

	property p_prog_n; // see [RULE1]
		@(posedge ref_clk) disable iff (!arst_n)
		ready && cfg.prog_en && !recovery_active
		|=> freq_out.prog && freq_out.n == $past(cfg.cpu_n);
	endproperty
	a_prog_n: assert property (p_prog_n) else $error("wrong program N");

	property p_rec_n; // see [RULE5]
		@(posedge ref_clk) disable iff (!arst_n)
		ready && recovery_active && cfg.rec_sel
		|=> freq_out.n == $past(cfg.rec_n) && freq_out.m == $past(cfg.rec_m);
	endproperty
	a_rec_n: assert property (p_rec_n) else $error("wrong recovery N/M");

	property p_load; // see [RULE2]
		@(posedge ref_clk) disable iff (!arst_n)
		started && load_cpu |=> freq_load;
	endproperty
	a_load: assert property (p_load) else $error("no load strobe");

	property p_strap_code; // see [RULE4]
		@(posedge ref_clk) disable iff (!arst_n)
		ready && !cfg.bypass |=> freq_out.code == $past(strap_latched);
	endproperty
	a_strap_code: assert property (p_strap_code)
		else $error("wrong speed code");

	property p_busy;
		@(posedge link_clk) disable iff (!arst_n)
		wr_ok |=> reg_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not raised");

endmodule : freq_program_watchdog_recovery
`default_nettype wire

// ==== link_host.sv ====
// partner: host on the register port, makes the link clock in frames
`timescale 1ns/1ps
`default_nettype none
module link_host (
	output logic            link_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [3:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_busy,
	output logic            hang
);
	logic run;

	// clock stands low between frames
	initial begin
		link_clk = 1'b0;
		run = 1'b0;
		hang = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		#5;
		forever begin
			#16;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end

	// one register per write; the next waits for busy to drop
	task automatic host_write(input logic [3:0] a, input logic [7:0] d);
		int n;
		run = 1'b1;
		repeat (3) @(posedge link_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge link_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		n = 0;
		do begin
			@(posedge link_clk);
			n++;
		end while (reg_busy !== 1'b0 && n < 64);
		if (n >= 64)
			hang = 1'b1;
		run = 1'b0;
	endtask : host_write

	// leading edges let the flag copy settle before the read
	task automatic host_read(input logic [3:0] a, output logic [7:0] d);
		run = 1'b1;
		repeat (3) @(posedge link_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge link_clk);
		reg_rd <= 1'b0;
		@(posedge link_clk);
		d = reg_rdata;
		run = 1'b0;
	endtask : host_read
endmodule : link_host
`default_nettype wire

// ==== freq_program_watchdog_recovery_test.sv ====
// testbench: frequency programming, watchdog and recovery control
`timescale 1ns/1ps
`default_nettype none
module freq_program_watchdog_recovery_test
	import fpw_pkg::*;
;
	localparam int SU = 20;
	localparam int LU = 50;
	logic        ref_clk, arst_n, link_clk, reg_wr, reg_rd, reg_busy, hang;
	logic        freq_load, recovery_active, sys_reset_pulse, rec_q;
	logic [4:0]  strap_speed_pins;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [22:0] pll_gear;
	freq_s       freq_out;
	logic [31:0] seed = 32'h37;
	int          errors, checks_done, cyc, load_cyc, span, pulses, width;

	freq_program_watchdog_recovery #(.SHORT_UNIT_CYCLES(SU),
		.LONG_UNIT_CYCLES(LU)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
		.link_clk(link_clk), .strap_speed_pins(strap_speed_pins),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_busy(reg_busy),
		.freq_out(freq_out), .pll_gear(pll_gear), .freq_load(freq_load),
		.recovery_active(recovery_active),
		.sys_reset_pulse(sys_reset_pulse));

	link_host u_host (.link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_busy(reg_busy), .hang(hang));

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xorshift

	function automatic freq_s exp_freq(logic p, logic [7:0] fn,
		logic [6:0] fm, logic [4:0] c);
		return '{prog: p, n: fn, m: fm, code: c};
	endfunction : exp_freq

	function automatic int timeout_cycles(int count, logic long_unit);
		return (count + 1) * (long_unit ? LU : SU);
	endfunction : timeout_cycles

	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic check_val(logic [22:0] got, logic [22:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check_val

	// a few cycles of slack for the crossing and the load pipeline
	task automatic check_span(int exp);
		checks_done++;
		if (span < exp - 3 || span > exp + 3) begin
			errors++;
			$display("Error at %0t: timeout after %0d, not %0d", $time, span, exp);
		end
	endtask : check_span

	task automatic wait_ref(int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_ref

	task automatic wait_rec();
		int k;
		k = 0;
		while (recovery_active !== 1'b1 && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 400) begin
			errors++;
			$display("Error at %0t: no recovery within bound", $time);
			report_and_stop();
		end
	endtask : wait_rec

	task automatic flag_is(logic exp);
		logic [7:0] d;
		u_host.host_read(ADDR_WD_CTL, d);
		check_val(d[WD_FLAG_BIT], exp);
	endtask : flag_is

	always @(posedge hang) begin
		errors++;
		$display("Error at %0t: register port busy never dropped", $time);
		report_and_stop();
	end

	// timeout span from the last load, reset pulse count and width
	always @(posedge ref_clk) begin
		cyc++;
		if (recovery_active === 1'b1 && !rec_q)
			span = cyc - load_cyc;
		rec_q = (recovery_active === 1'b1);
		if (freq_load === 1'b1)
			load_cyc = cyc;
		if (sys_reset_pulse === 1'b1)
			width++;
		else if (width != 0) begin
			pulses++;
			check_val(width, RST_PULSE_CYC);
			width = 0;
		end
	end

	initial begin
		logic [31:0] r;
		logic [7:0]  n, d;
		logic [4:0]  sw;
		int          p0;
		arst_n = 1'b0;
		rec_q = 1'b0;
		r = xorshift();
		strap_speed_pins = r[4:0];
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		wait_ref(8);
		check_val(pll_gear, GEAR_E5);
		check_val(freq_out.prog, 0);
		check_val(freq_out.code, strap_speed_pins);
		for (int a = 0; a < 8; a++) begin
			u_host.host_read(a[3:0], d);
			check_val(d, 0);
		end
		u_host.host_write(4'h9, 8'hff);
		u_host.host_read(4'h9, d);
		check_val(d, 0);
		u_host.host_write(ADDR_FREQ_CT, 8'h01);
		r = xorshift();
		// n stays below 255 so that n+1 later keeps the ratio above one
		n = 8'd97 + 8'(r % 158);
		u_host.host_write(ADDR_CPU_N, n);
		check_val(freq_out, exp_freq(1'b1, n, 7'h00, strap_speed_pins));
		u_host.host_write(ADDR_CPU_M, 8'd93);
		check_val(freq_out, exp_freq(1'b1, n, 7'd93, strap_speed_pins));
		r = xorshift();
		sw = r[4:0];
		u_host.host_write(ADDR_SW_CODE, {3'h0, sw});
		u_host.host_write(ADDR_FREQ_CT, 8'h03);
		check_val(freq_out, exp_freq(1'b1, n, 7'd93, sw));
		u_host.host_write(ADDR_FREQ_CT, 8'h02);
		check_val(freq_out.prog, 0);
		check_val(freq_out.code, sw);
		u_host.host_write(ADDR_FREQ_CT, 8'h01);
		// short unit, count 1, reset on timeout only
		u_host.host_write(ADDR_WD_TIME, 8'h01);
		u_host.host_write(ADDR_WD_CTL, 8'h05);
		wait_ref(100);
		check_val(recovery_active, 0);
		p0 = pulses;
		u_host.host_write(ADDR_CPU_N, n + 8'h01);
		wait_rec();
		wait_ref(24);
		check_span(timeout_cycles(1, 1'b0));
		check_val(freq_out.code, strap_speed_pins);
		check_val(pulses, p0 + 1);
		flag_is(1'b1);
		u_host.host_write(ADDR_WD_CTL, 8'h05);
		flag_is(1'b1);
		u_host.host_write(ADDR_WD_CTL, 8'h15);
		flag_is(1'b0);
		// long unit, recovery from programmed values, both resets on
		r = xorshift();
		n = 8'd127 + 8'(r % 119);
		u_host.host_write(ADDR_REC_N, n);
		u_host.host_write(ADDR_REC_M, 8'd45);
		u_host.host_write(ADDR_FREQ_CT, 8'h05);
		u_host.host_write(ADDR_WD_TIME, 8'h00);
		u_host.host_write(ADDR_WD_CTL, 8'h0f);
		p0 = pulses;
		u_host.host_write(ADDR_CPU_N, 8'hf0);
		wait_rec();
		wait_ref(24);
		check_span(timeout_cycles(0, 1'b1));
		check_val(freq_out, exp_freq(1'b1, n, 7'd45, strap_speed_pins));
		check_val(pulses, p0 + 2);
		u_host.host_write(ADDR_REC_N, n - 8'h01);
		wait_ref(24);
		check_val(freq_out.n, n - 8'h01);
		check_val(pulses, p0 + 3);
		u_host.host_write(ADDR_WD_CTL, 8'h18);
		check_val(recovery_active, 0);
		u_host.host_write(ADDR_CPU_N, 8'he0);
		wait_ref(200);
		check_val(recovery_active, 0);
		// timeout with both reset enables clear gives no pulse
		u_host.host_write(ADDR_WD_CTL, 8'h01);
		p0 = pulses;
		u_host.host_write(ADDR_CPU_N, 8'hd0);
		wait_rec();
		wait_ref(24);
		check_val(pulses, p0);
		u_host.host_write(ADDR_WD_CTL, 8'h10);
		flag_is(1'b0);
		report_and_stop();
	end
endmodule : freq_program_watchdog_recovery_test
`default_nettype wire
